/* File: bench/nested_interrupt_expander_bench.sv */
// bench: table of single sources, then priority, nesting and gating cases
`timescale 1ns/10ps
module nested_interrupt_expander_bench;
  import nie_pkg::*;
  typedef struct { int src; logic [3:0] line; logic [6:0] vec; } nie_row_t;
  logic sys_clk = 1'h0, resetn = 1'h0, nmi_in = 1'h0;
  logic [95:0] periph_irq = '0;
  logic [3:0] direct_irq = 4'h0, grp_en_sel = 4'h0, irq_line, nest_depth;
  logic line_en_we = 1'h0, grp_en_we = 1'h0, ack_we = 1'h0;
  logic mask_set = 1'h0, mask_clr = 1'h0, irq_taken, irq_return;
  logic [15:0] line_en_wdata = 16'h0, ack_wdata = 16'h0, cpu_line_enable_reg;
  logic [15:0] cpu_interrupt_lines;
  logic [7:0] grp_en_wdata = 8'h0, grp_en_rdata, g_save;
  logic [11:0] group_acknowledge_reg;
  logic global_interrupt_mask, irq_req, nmi_req, entry_busy;
  logic [6:0] irq_vector;
  logic core_en = 1'h0, ret_en = 1'h1;
  int err_count = 0, cmp_count = 0, cyc = 0, n;
  nie_row_t rows [4] = '{'{0, 4'h0, 7'h00}, '{13, 4'h1, 7'h0D},
                         '{47, 4'h5, 7'h2F}, '{95, 4'hB, 7'h5F}};
  nie_ctrl dut (
    .sys_clk               (sys_clk),
    .resetn                (resetn),
    .periph_irq            (periph_irq),
    .direct_irq            (direct_irq),
    .nmi_in                (nmi_in),
    .line_en_we            (line_en_we),
    .line_en_wdata         (line_en_wdata),
    .grp_en_we             (grp_en_we),
    .grp_en_sel            (grp_en_sel),
    .grp_en_wdata          (grp_en_wdata),
    .ack_we                (ack_we),
    .ack_wdata             (ack_wdata),
    .mask_set              (mask_set),
    .mask_clr              (mask_clr),
    .irq_taken             (irq_taken),
    .irq_return            (irq_return),
    .cpu_line_enable_reg   (cpu_line_enable_reg),
    .grp_en_rdata          (grp_en_rdata),
    .group_acknowledge_reg (group_acknowledge_reg),
    .global_interrupt_mask (global_interrupt_mask),
    .cpu_interrupt_lines   (cpu_interrupt_lines),
    .irq_req               (irq_req),
    .nmi_req               (nmi_req),
    .irq_line              (irq_line),
    .irq_vector            (irq_vector),
    .entry_busy            (entry_busy),
    .nest_depth            (nest_depth)
  );
  nie_core_model #(.LAT(3)) core (.sys_clk(sys_clk), .core_en(core_en),
    .ret_en(ret_en), .irq_req(irq_req), .entry_busy(entry_busy),
    .irq_taken(irq_taken), .irq_return(irq_return));
  always #4 sys_clk = ~sys_clk;
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic wr_line(input logic [15:0] v);
    @(negedge sys_clk); line_en_wdata = v; line_en_we = 1'h1;
    @(negedge sys_clk); line_en_we = 1'h0;
  endtask : wr_line
  task automatic wr_grp(input int g, input logic [7:0] v);
    @(negedge sys_clk); grp_en_sel = 4'(g); grp_en_wdata = v; grp_en_we = 1'h1;
    @(negedge sys_clk); grp_en_we = 1'h0;
  endtask : wr_grp
  task automatic wr_ack(input logic [15:0] v);
    @(negedge sys_clk); ack_wdata = v; ack_we = 1'h1;
    @(negedge sys_clk); ack_we = 1'h0;
  endtask : wr_ack
  task automatic msk(input logic s);
    @(negedge sys_clk); mask_set = s; mask_clr = !s;
    @(negedge sys_clk); mask_set = 1'h0; mask_clr = 1'h0;
  endtask : msk
  // take one request and measure how long entry stays busy
  task automatic take;
    core_en = 1'h1;
    for (int i = 0; i < 20 && entry_busy !== 1'h1; i++) @(negedge sys_clk);
    core_en = 1'h0;
    n = 0;
    while (entry_busy === 1'h1 && n < 40) begin
      n++;
      @(negedge sys_clk);
    end
  endtask : take
  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    chk(cpu_line_enable_reg, NIE_LINE_EN_RST);
    chk(group_acknowledge_reg, NIE_ACK_RST);
    chk(global_interrupt_mask, 1'h1);
    chk(irq_vector, NIE_VEC_NONE);
    chk(cpu_interrupt_lines, 16'h0);
    resetn = 1'h1;
    wr_line(16'hFFFF);
    foreach (rows[r]) begin
      wr_grp(rows[r].src / 8, 8'hFF);
      msk(1'h0);
      periph_irq[rows[r].src] = 1'h1;
      repeat (6) @(negedge sys_clk);
      chk(irq_line, rows[r].line);
      chk(cpu_interrupt_lines[rows[r].line], 1'h1);
      take();
      chk(irq_vector, rows[r].vec);
      chk(group_acknowledge_reg[rows[r].src / 8], 1'h1);
      chk(global_interrupt_mask, 1'h1);
      // the take cycle itself is the first cycle of the entry window
      chk(16'(n + 1), 16'(NIE_ENTRY_CYC));
      periph_irq = '0;
      wr_ack(NIE_ACK_ALL);
      chk(group_acknowledge_reg, 12'h000);
      // let the core model return before the next case
      repeat (2) @(negedge sys_clk);
      chk(nest_depth, 4'h0);
    end
    // three pending in two groups, then a nested higher source
    ret_en = 1'h0;
    periph_irq[13] = 1'h1; periph_irq[10] = 1'h1; periph_irq[40] = 1'h1;
    msk(1'h0);
    repeat (6) @(negedge sys_clk);
    chk(irq_line, 4'h1);
    take();
    chk(irq_vector, 7'h0A);
    grp_en_sel = 4'h1;
    #1 g_save = grp_en_rdata;
    wr_line(16'h0001);
    chk(cpu_line_enable_reg, 16'h0001);
    wr_grp(1, 8'h01);
    chk(grp_en_rdata, 8'h01);
    wr_ack(NIE_ACK_ALL);
    msk(1'h0);
    periph_irq[0] = 1'h1;
    repeat (6) @(negedge sys_clk);
    chk(cpu_interrupt_lines, 16'h0001);
    take();
    chk(nest_depth, 4'h2);
    chk(irq_vector, 7'h00);
    msk(1'h1);
    wr_grp(1, g_save);
    chk(grp_en_rdata, 8'hFF);
    ret_en = 1'h1;
    // group enable gating, mask, ack blocking
    periph_irq = '0;
    wr_ack(NIE_ACK_ALL);
    wr_line(16'hFFFF);
    wr_grp(3, 8'hFE);
    periph_irq[24] = 1'h1;
    repeat (6) @(negedge sys_clk);
    chk(cpu_interrupt_lines[3], 1'h0);
    periph_irq[25] = 1'h1;
    repeat (6) @(negedge sys_clk);
    chk(cpu_interrupt_lines[3], 1'h1);
    chk(irq_req, 1'h0);
    msk(1'h0);
    chk(irq_req, 1'h1);
    take();
    chk(irq_vector, 7'h19);
    repeat (4) @(negedge sys_clk);
    chk(cpu_interrupt_lines[3], 1'h0);
    // direct line and nmi
    periph_irq = '0;
    direct_irq = 4'h1;
    nmi_in = 1'h1;
    msk(1'h0);
    repeat (6) @(negedge sys_clk);
    chk(cpu_interrupt_lines[12], 1'h1);
    chk(nmi_req, 1'h1);
    take();
    chk(irq_vector, NIE_VEC_NONE);
    // reset in mid-run with the direct line and nmi still high
    repeat (4) @(negedge sys_clk);
    resetn = 1'h0;
    @(negedge sys_clk);
    chk(nest_depth, 4'h0);
    chk(global_interrupt_mask, 1'h1);
    chk(cpu_interrupt_lines, 16'h0);
    chk(nmi_req, 1'h0);
    resetn = 1'h1;
    repeat (3) @(negedge sys_clk);
    chk(nmi_req, 1'h1);
    chk(cpu_interrupt_lines, 16'h0);
    chk(irq_req, 1'h0);
    end_sim();
  end
endmodule : nested_interrupt_expander_bench

/* File: bench/nie_core_model.sv */
// core model: takes offered requests, returns after each routine
`timescale 1ns/10ps
module nie_core_model #(parameter int LAT = 1) (
  input  wire logic sys_clk,
  input  wire logic core_en,
  input  wire logic ret_en,
  input  wire logic irq_req,
  input  wire logic entry_busy,
  output logic      irq_taken,
  output logic      irq_return
);
  logic busy_q;
  int   cnt;
  initial begin
    irq_taken = 1'h0;
    irq_return = 1'h0;
    busy_q = 1'h0;
    cnt = 0;
  end
  // moves after the falling edge; the design samples on the rising one
  always @(negedge sys_clk) begin
    irq_taken <= core_en && irq_req === 1'h1 && !irq_taken;
    busy_q <= entry_busy;
    irq_return <= ret_en && cnt == 1;
    if (busy_q && entry_busy === 1'h0) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : nie_core_model

/* File: inc/nie_pkg.sv */
// package: sizes, priorities and timing constants of the interrupt expander
package nie_pkg;
  localparam int unsigned NIE_GROUPS     = 12;
  localparam int unsigned NIE_POSITIONS  = 8;
  localparam int unsigned NIE_CPU_LINES  = 16;
  localparam int unsigned NIE_SRC_COUNT  = NIE_GROUPS * NIE_POSITIONS;
  localparam int unsigned NIE_VEC_W      = 7;
  localparam int unsigned NIE_LINE_W     = 4;
  localparam int unsigned NIE_POS_W      = 3;
  // fixed global levels: reset 1, nmi 3, line one at 5 and down from there
  localparam int unsigned NIE_LVL_RESET  = 1;
  localparam int unsigned NIE_LVL_NMI    = 3;
  localparam int unsigned NIE_LVL_LINE1  = 5;
  // entry latency into a prioritized routine, in core cycles
  localparam int unsigned NIE_ENTRY_CYC  = 22;
  localparam logic [15:0] NIE_ACK_ALL    = 16'hFFFF;
  localparam logic [15:0] NIE_LINE_EN_RST = 16'h0000;
  localparam logic [7:0]  NIE_GRP_EN_RST = 8'h00;
  localparam logic [11:0] NIE_ACK_RST    = 12'h000;
  localparam logic [6:0]  NIE_VEC_NONE   = 7'h7F;
endpackage : nie_pkg

/* File: src/nie_ctrl.sv */
// nested interrupt expander top: groups, line enables, mask, acknowledge
`timescale 1ns/10ps
module nie_ctrl
  import nie_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [95:0] periph_irq,
  input  wire logic [3:0]  direct_irq,
  input  wire logic        nmi_in,
  input  wire logic        line_en_we,
  input  wire logic [15:0] line_en_wdata,
  input  wire logic        grp_en_we,
  input  wire logic [3:0]  grp_en_sel,
  input  wire logic [7:0]  grp_en_wdata,
  input  wire logic        ack_we,
  input  wire logic [15:0] ack_wdata,
  input  wire logic        mask_set,
  input  wire logic        mask_clr,
  input  wire logic        irq_taken,
  input  wire logic        irq_return,
  output logic [15:0]      cpu_line_enable_reg,
  output logic [7:0]       grp_en_rdata,
  output logic [11:0]      group_acknowledge_reg,
  output logic             global_interrupt_mask,
  output logic [15:0]      cpu_interrupt_lines,
  output logic             irq_req,
  output logic             nmi_req,
  output logic [3:0]       irq_line,
  output logic [6:0]       irq_vector,
  output logic             entry_busy,
  output logic [3:0]       nest_depth
);
  // =========================================================
  // state
  typedef struct packed {
    logic [95:0] sync1;
    logic [95:0] sync2;
    logic [3:0]  dsync1;
    logic [3:0]  dsync2;
    logic        nsync1;
    logic        nsync2;
    logic [15:0] line_en;
    logic [95:0] grp_en;
    logic [11:0] ack;
    logic        gmask;
    logic [15:0] lines;
    logic [6:0]  vec;
    logic [3:0]  line;
    logic [4:0]  entry_cnt;
    logic [3:0]  depth;
  } nie_state_t;

  nie_state_t st_r, st_nxt;

  logic [11:0] g_any;
  logic [2:0]  g_pos [NIE_GROUPS];
  logic [15:0] raw_lines;
  logic        found;
  logic [3:0]  win;

  localparam logic [4:0] ENTRY_LAST = 5'(NIE_ENTRY_CYC - 1);

  function automatic logic [6:0] vec_of(input logic [3:0] g,
                                        input logic [2:0] p);
    vec_of = 7'({3'h0, g} * NIE_POSITIONS) + 7'(p);
  endfunction : vec_of

  // =========================================================
  // group stage
  genvar gi;
  generate
    for (gi = 0; gi < NIE_GROUPS; gi++) begin : g_grp
      nie_group_pick u_pick (
        .pend   (st_r.sync2[gi*NIE_POSITIONS +: NIE_POSITIONS]),
        .enable (st_r.grp_en[gi*NIE_POSITIONS +: NIE_POSITIONS]),
        .any    (g_any[gi]),
        .pos    (g_pos[gi])
      );
    end
  endgenerate

  // =========================================================
  // line stage and next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1  = periph_irq;
    st_nxt.sync2  = st_r.sync1;
    st_nxt.dsync1 = direct_irq;
    st_nxt.dsync2 = st_r.dsync1;
    st_nxt.nsync1 = nmi_in;
    st_nxt.nsync2 = st_r.nsync1;
    // lines 1..12 from groups, blocked while their ack bit stands
    raw_lines = {st_r.dsync2, g_any & ~st_r.ack};
    st_nxt.lines = raw_lines & st_r.line_en;
    found = 1'b0;
    win   = 4'h0;
    for (int i = NIE_CPU_LINES - 1; i >= 0; i--) begin
      if (st_r.lines[i]) begin
        found = 1'b1;
        win   = NIE_LINE_W'(i);
      end
    end
    if (line_en_we) begin
      st_nxt.line_en = line_en_wdata;
    end
    if (grp_en_we && grp_en_sel < 4'(NIE_GROUPS)) begin
      st_nxt.grp_en[grp_en_sel*NIE_POSITIONS +: NIE_POSITIONS] = grp_en_wdata;
    end
    if (ack_we) begin
      st_nxt.ack = st_r.ack & ~ack_wdata[11:0];
    end
    if (mask_clr) begin
      st_nxt.gmask = 1'b0;
    end
    if (mask_set) begin
      st_nxt.gmask = 1'b1;
    end
    if (st_r.entry_cnt != 5'h0) begin
      st_nxt.entry_cnt = st_r.entry_cnt - 5'h1;
    end
    if (irq_return && st_r.depth != 4'h0) begin
      st_nxt.depth = st_r.depth - 4'h1;
    end
    if (irq_taken && irq_req) begin
      // core entry masks further maskable interrupts until software unmasks
      st_nxt.gmask     = 1'b1;
      st_nxt.entry_cnt = ENTRY_LAST;
      st_nxt.vec       = st_r.line < 4'(NIE_GROUPS)
                         ? vec_of(st_r.line, g_pos[st_r.line]) : NIE_VEC_NONE;
      if (st_r.line < 4'(NIE_GROUPS)) begin
        st_nxt.ack[st_r.line] = 1'b1;
      end
      if (!(irq_return && st_r.depth != 4'h0)) begin
        st_nxt.depth = st_r.depth + 4'h1;
      end
    end
    st_nxt.line = win;
    if (!found) begin
      st_nxt.line = st_r.line;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r         <= '0;
      st_r.line_en <= NIE_LINE_EN_RST;
      st_r.ack     <= NIE_ACK_RST;
      st_r.gmask   <= 1'b1;
      st_r.vec     <= NIE_VEC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =========================================================
  // outputs
  assign cpu_line_enable_reg   = st_r.line_en;
  assign group_acknowledge_reg = st_r.ack;
  assign global_interrupt_mask = st_r.gmask;
  assign cpu_interrupt_lines   = st_r.lines;
  assign irq_req   = (|st_r.lines) && !st_r.gmask && st_r.entry_cnt == 5'h0;
  assign nmi_req   = st_r.nsync2;
  assign irq_line  = st_r.line;
  assign irq_vector = st_r.vec;
  assign entry_busy = st_r.entry_cnt != 5'h0;
  assign nest_depth = st_r.depth;
  assign grp_en_rdata = grp_en_sel < 4'(NIE_GROUPS)
         ? st_r.grp_en[grp_en_sel*NIE_POSITIONS +: NIE_POSITIONS] : 8'h00;

  // =========================================================
  // checks
  a_mask_blocks: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    st_r.gmask |-> !irq_req)
    else $error("request while global mask set");
  a_line_gated: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (cpu_interrupt_lines & ~$past(st_r.line_en)) == 16'h0000)
    else $error("disabled line reached core");
  a_ack_blocks: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (irq_taken && irq_req && st_r.line < 4'(NIE_GROUPS) && !ack_we)
    |=> st_r.ack[$past(st_r.line)])
    else $error("group ack not set on forward");
  a_ack_all: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ack_we && ack_wdata == NIE_ACK_ALL && !irq_taken)
    |=> st_r.ack == 12'h000)
    else $error("ack all did not re-arm");
  a_entry_time: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (irq_taken && irq_req) |=> entry_busy [*8])
    else $error("entry window too short");
  // take cycle plus the busy cycles make up the whole entry window
  a_entry_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (irq_taken && irq_req) |-> ##21 entry_busy)
    else $error("entry window ends early");
  a_entry_end: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (irq_taken && irq_req) |-> ##22 !entry_busy)
    else $error("entry window too long");
  a_taken_masks: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (irq_taken && irq_req && !mask_clr) |=> global_interrupt_mask)
    else $error("entry did not mask");
  a_lowest_wins: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (|cpu_interrupt_lines) |=>
      ((($past(cpu_interrupt_lines) >> irq_line) & 16'h0001) == 16'h0001)
      && (($past(cpu_interrupt_lines)
           & ((16'h0001 << irq_line) - 16'h0001)) == 16'h0000))
    else $error("priority pick wrong");
  a_pick_first: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_r.lines[0]) |=> irq_line == 4'h0)
    else $error("line one not highest");

  c_take: cover property (@(posedge sys_clk) disable iff (!resetn)
    irq_taken && irq_req);
  c_nest: cover property (@(posedge sys_clk) disable iff (!resetn)
    nest_depth == 4'h2);
  c_ack_all: cover property (@(posedge sys_clk) disable iff (!resetn)
    ack_we && ack_wdata == NIE_ACK_ALL);
endmodule : nie_ctrl

/* File: src/nie_group_pick.sv */
// one expansion group: enable gating and fixed position priority
`timescale 1ns/10ps
module nie_group_pick
  import nie_pkg::*;
(
  input  wire logic [7:0] pend,
  input  wire logic [7:0] enable,
  output logic            any,
  output logic [2:0]      pos
);
  logic [7:0] live;
  always_comb begin
    live = pend & enable;
    any  = |live;
    pos  = 3'h0;
    for (int i = NIE_POSITIONS - 1; i >= 0; i--) begin
      if (live[i]) begin
        pos = NIE_POS_W'(i);
      end
    end
  end
endmodule : nie_group_pick
